// ===== shared/tic_consts.svh
/*
 * Constants of the time interval counter: register addresses, field
 * positions, reset values and count limits.
 * Assumes it is included by bare name from the design files.
 */
`ifndef TIC_CONSTS_SVH
`define TIC_CONSTS_SVH

`define TIC_ADDR_CTRL     8'ha1
`define TIC_ADDR_TICK     8'ha2
`define TIC_ADDR_SEC      8'ha3
`define TIC_ADDR_MIN      8'ha4
`define TIC_ADDR_HOUR     8'ha5
`define TIC_ADDR_CMP      8'ha6

`define TIC_CTRL_RESET    6'h00
`define TIC_CMP_RESET     8'h00
`define TIC_TIME_RESET    8'h00

`define TIC_BIT_TIMECLOCK_ENABLE      0
`define TIC_BIT_INTERVAL_ENABLE      1
`define TIC_BIT_FLAG      2
`define TIC_BIT_SSHOT     3
`define TIC_BIT_TB_LO     4
`define TIC_BIT_TB_HI     5

`define TIC_TB_TICK       2'h0
`define TIC_TB_SEC        2'h1
`define TIC_TB_MIN        2'h2
`define TIC_TB_HOUR       2'h3

`define TIC_PRESC_MAX     8'hff
`define TIC_TICK_MAX      8'h7f
`define TIC_SEC_MAX       8'h3b
`define TIC_MIN_MAX       8'h3b
`define TIC_HOUR_MAX      8'h17

`define TIC_ISR_VECTOR    16'h0053

`endif

// ===== shared/tic_pkg.sv
/*
 * Types of the time interval counter: control fields and module state.
 * Assumes nothing beyond the constants header.
 */
package tic_pkg;

    typedef struct packed {
        logic [1:0] tb_sel;
        logic       single_shot;
        logic       interval_flag;
        logic       interval_enable;
        logic       timeclock_enable;
    } tic_ctrl_t;

    typedef struct packed {
        tic_ctrl_t  ctrl;
        logic [7:0] compare;
        logic [7:0] ivl_cnt;
        logic [7:0] presc;
        logic       xs1;
        logic       xs2;
        logic       xs3;
        logic [7:0] rdata;
    } tic_state_t;

    typedef struct packed {
        logic [7:0] count;
    } tic_cnt_state_t;

endpackage

// ===== shared/tic_cnt_if.sv
/*
 * Carrier between the time interval counter and one time register.
 * Assumes a single clock shared by both ends.
 */
`timescale 1ns/10ps
interface tic_cnt_if;
    logic       inc;
    logic       clr;
    logic       load;
    logic [7:0] ld_val;
    logic [7:0] count;
    logic       wrap;

    modport ctl (output inc, output clr, output load, output ld_val,
                 input count, input wrap);
    modport cnt (input inc, input clr, input load, input ld_val,
                 output count, output wrap);
endinterface

// ===== core/tic_wrap_counter.sv
/*
 * One time register: counts 0..MAX, wraps to zero and flags the wrap.
 * Assumes clr, load and inc come from the same clock domain.
 */
`timescale 1ns/10ps
`include "tic_consts.svh"
module tic_wrap_counter #(
    parameter logic [7:0] MAX = 8'h3b
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    tic_cnt_if.cnt    cif
);

    tic_pkg::tic_cnt_state_t st_ff;
    tic_pkg::tic_cnt_state_t nxt_st;

    // Out-of-range presets still wrap at the first step
    assign cif.wrap  = cif.inc && (st_ff.count >= MAX);
    assign cif.count = st_ff.count;

    always_comb
    begin
        nxt_st = st_ff;
        if (cif.clr)
            nxt_st.count = `TIC_TIME_RESET;
        else if (cif.load)
            nxt_st.count = cif.ld_val;
        else if (cif.wrap)
            nxt_st.count = 8'h00;
        else if (cif.inc)
            nxt_st.count = st_ff.count + 8'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    a_count_range: assert property (
        @(posedge ref_clk) disable iff (srst)
        (!cif.load && !$past(cif.load)) |-> (st_ff.count <= MAX))
        else $error("time register out of range");

endmodule

// ===== core/tic_timer.sv
/*
 * Time interval counter: 1/128 s, second, minute and hour registers,
 * an 8-bit interval counter with compare, flag and wake request, and
 * the special-function register port.
 * Assumes xtal_clk is the crystal level, slow against ref_clk, and
 * that the core samples sfr_rdata one cycle after sfr_rd.
 */
// Behaviour
// - Interval timer runs from crystal edges, unaffected by power-down.
// - Timeouts span one 1/128 s tick up to 255 hours; a compare of zero here gives 256 hours.
// - Timebase select picks tick, second, minute or hour overflow.
// - Counter equal to compare sets the flag; interrupt if enabled.
// - Flag in power-down with interrupt enabled wakes core to vector.
// - Single-shot mode gives one timeout which clears interval enable.
// - Without single-shot the counter reloads and keeps counting.
// - Interval enable runs the counter; clearing it zeroes the counter.
// - Time clock enable gates time registers; clearing it clears them.
// - Time registers accept writes only while time clock is off.
// - Control register sits at A1H and resets to zero.
// - Tick register counts 0 to 127, wrap advances seconds.
// - Seconds and minutes count 0 to 59, wrap advances next.
// - Hours count 0 to 23 then wrap to zero.
`timescale 1ns/10ps
`include "tic_consts.svh"
module tic_timer (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        xtal_clk,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        irq_enable,
    input  wire logic        power_down,
    output logic             irq_req,
    output logic             wake_req,
    output logic      [15:0] wake_vector
);

    tic_pkg::tic_state_t st_ff;
    tic_pkg::tic_state_t nxt_st;

    tic_cnt_if tick_if ();
    tic_cnt_if sec_if ();
    tic_cnt_if min_if ();
    tic_cnt_if hour_if ();

    logic       wr_ctrl;
    logic       xedge;
    logic       presc_ovf;
    logic       tb_evt;
    logic [7:0] ivl_next;
    logic       timeout;
    logic       tc_stop;
    logic       time_wr_ok;

    tic_wrap_counter #(.MAX(`TIC_TICK_MAX)) u_tick (
        .ref_clk (ref_clk),
        .srst    (srst),
        .cif     (tick_if)
    );
    tic_wrap_counter #(.MAX(`TIC_SEC_MAX)) u_sec (
        .ref_clk (ref_clk),
        .srst    (srst),
        .cif     (sec_if)
    );
    tic_wrap_counter #(.MAX(`TIC_MIN_MAX)) u_min (
        .ref_clk (ref_clk),
        .srst    (srst),
        .cif     (min_if)
    );
    tic_wrap_counter #(.MAX(`TIC_HOUR_MAX)) u_hour (
        .ref_clk (ref_clk),
        .srst    (srst),
        .cif     (hour_if)
    );

    assign wr_ctrl = sfr_wr && (sfr_addr == `TIC_ADDR_CTRL);
    // Second stage against third only; first stage feeds nothing else
    assign xedge     = st_ff.xs2 && !st_ff.xs3;
    assign presc_ovf = xedge && st_ff.ctrl.timeclock_enable
                       && (st_ff.presc == `TIC_PRESC_MAX);
    // Clearing the time clock also clears the time registers
    assign tc_stop    = wr_ctrl && st_ff.ctrl.timeclock_enable
                        && !sfr_wdata[`TIC_BIT_TIMECLOCK_ENABLE];
    assign time_wr_ok = sfr_wr && !st_ff.ctrl.timeclock_enable;

    assign tick_if.inc  = presc_ovf;
    assign sec_if.inc   = tick_if.wrap;
    assign min_if.inc   = sec_if.wrap;
    assign hour_if.inc  = min_if.wrap;
    assign tick_if.clr  = tc_stop;
    assign sec_if.clr   = tc_stop;
    assign min_if.clr   = tc_stop;
    assign hour_if.clr  = tc_stop;
    assign tick_if.load = time_wr_ok && (sfr_addr == `TIC_ADDR_TICK);
    assign sec_if.load  = time_wr_ok && (sfr_addr == `TIC_ADDR_SEC);
    assign min_if.load  = time_wr_ok && (sfr_addr == `TIC_ADDR_MIN);
    assign hour_if.load = time_wr_ok && (sfr_addr == `TIC_ADDR_HOUR);
    assign tick_if.ld_val = sfr_wdata;
    assign sec_if.ld_val  = sfr_wdata;
    assign min_if.ld_val  = sfr_wdata;
    assign hour_if.ld_val = sfr_wdata;

    always_comb
    begin
        case (st_ff.ctrl.tb_sel)
            `TIC_TB_TICK: tb_evt = presc_ovf;
            `TIC_TB_SEC:  tb_evt = tick_if.wrap;
            `TIC_TB_MIN:  tb_evt = sec_if.wrap;
            `TIC_TB_HOUR: tb_evt = min_if.wrap;
            default:      tb_evt = 1'b0;
        endcase
    end

    // Compare of zero is reached after 256 steps, the 8-bit wrap
    assign ivl_next = st_ff.ivl_cnt + 8'h01;
    assign timeout  = st_ff.ctrl.interval_enable && tb_evt
                      && (ivl_next == st_ff.compare);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.xs1 = xtal_clk;
        nxt_st.xs2 = st_ff.xs1;
        nxt_st.xs3 = st_ff.xs2;

        // Prescaler held at zero while the time clock is off
        if (!st_ff.ctrl.timeclock_enable)
            nxt_st.presc = 8'h00;
        else if (xedge)
            nxt_st.presc = st_ff.presc + 8'h01;

        if (wr_ctrl)
        begin
            nxt_st.ctrl.tb_sel = sfr_wdata[`TIC_BIT_TB_HI:`TIC_BIT_TB_LO];
            nxt_st.ctrl.single_shot = sfr_wdata[`TIC_BIT_SSHOT];
            nxt_st.ctrl.interval_flag = sfr_wdata[`TIC_BIT_FLAG];
            nxt_st.ctrl.interval_enable = sfr_wdata[`TIC_BIT_INTERVAL_ENABLE];
            nxt_st.ctrl.timeclock_enable = sfr_wdata[`TIC_BIT_TIMECLOCK_ENABLE];
        end
        if (sfr_wr && (sfr_addr == `TIC_ADDR_CMP))
            nxt_st.compare = sfr_wdata;

        if (st_ff.ctrl.interval_enable && tb_evt)
            nxt_st.ivl_cnt = ivl_next;
        if (timeout)
        begin
            // Hardware set beats a software clear in the same cycle
            nxt_st.ctrl.interval_flag = 1'b1;
            nxt_st.ivl_cnt = 8'h00;
            if (st_ff.ctrl.single_shot)
                nxt_st.ctrl.interval_enable = 1'b0;
        end
        if (!nxt_st.ctrl.interval_enable)
            nxt_st.ivl_cnt = 8'h00;

        if (sfr_rd)
        begin
            case (sfr_addr)
                `TIC_ADDR_CTRL: nxt_st.rdata = {2'b00, st_ff.ctrl};
                `TIC_ADDR_TICK: nxt_st.rdata = tick_if.count;
                `TIC_ADDR_SEC:  nxt_st.rdata = sec_if.count;
                `TIC_ADDR_MIN:  nxt_st.rdata = min_if.count;
                `TIC_ADDR_HOUR: nxt_st.rdata = hour_if.count;
                `TIC_ADDR_CMP:  nxt_st.rdata = st_ff.compare;
                default:        nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_ff <= '0;
            st_ff.ctrl <= `TIC_CTRL_RESET;
            st_ff.compare <= `TIC_CMP_RESET;
        end
        else
            st_ff <= nxt_st;
    end

    assign sfr_rdata   = st_ff.rdata;
    assign irq_req     = st_ff.ctrl.interval_flag && irq_enable;
    assign wake_req    = irq_req && power_down;
    assign wake_vector = `TIC_ISR_VECTOR;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Interval counter and flag
    a_flag_on_match: assert property (
        timeout |=> st_ff.ctrl.interval_flag)
        else $error("flag not set on match");
    a_flag_hold: assert property (
        (st_ff.ctrl.interval_flag && !wr_ctrl) |=> st_ff.ctrl.interval_flag)
        else $error("flag dropped without software");
    a_flag_clear: assert property (
        (wr_ctrl && !sfr_wdata[`TIC_BIT_FLAG] && !timeout)
        |=> !st_ff.ctrl.interval_flag)
        else $error("software clear of flag lost");
    a_wake_power_down: assert property (
        (power_down && irq_enable && timeout)
        |=> wake_req && (wake_vector == `TIC_ISR_VECTOR))
        else $error("no wake after timeout in power-down");
    a_single_shot_off: assert property (
        (timeout && st_ff.ctrl.single_shot && !wr_ctrl)
        |=> !st_ff.ctrl.interval_enable ##1 !timeout)
        else $error("single shot did not stop");
    a_periodic_reload: assert property (
        (timeout && !st_ff.ctrl.single_shot && !wr_ctrl)
        |=> (st_ff.ivl_cnt == 8'h00) && st_ff.ctrl.interval_enable)
        else $error("no reload after timeout");
    a_disabled_zero: assert property (
        !st_ff.ctrl.interval_enable |-> (st_ff.ivl_cnt == 8'h00))
        else $error("interval counter not zero while disabled");
    a_enable_write: assert property (
        (wr_ctrl && !sfr_wdata[`TIC_BIT_INTERVAL_ENABLE])
        |=> !st_ff.ctrl.interval_enable && (st_ff.ivl_cnt == 8'h00))
        else $error("interval enable clear not taken");
    a_base_select: assert property (
        ((st_ff.ctrl.tb_sel == `TIC_TB_SEC) && st_ff.ctrl.interval_enable
        && sec_if.inc && !timeout && !wr_ctrl)
        |=> (st_ff.ivl_cnt == $past(ivl_next)))
        else $error("seconds base not counted");
    a_tick_base: assert property (
        ((st_ff.ctrl.tb_sel == `TIC_TB_TICK) && !tick_if.inc && !wr_ctrl)
        |=> $stable(st_ff.ivl_cnt))
        else $error("tick base counted without a tick");
    a_hour_base: assert property (
        ((st_ff.ctrl.tb_sel == `TIC_TB_HOUR) && !hour_if.inc && !wr_ctrl)
        |=> $stable(st_ff.ivl_cnt))
        else $error("hour base counted without an hour");

    // Register access
    a_cmp_write: assert property (
        (sfr_wr && (sfr_addr == `TIC_ADDR_CMP))
        |=> (st_ff.compare == $past(sfr_wdata)))
        else $error("compare write lost");
    a_rdata_hold: assert property (
        !sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
    a_rsvd_zero: assert property (
        (sfr_rd && (sfr_addr == `TIC_ADDR_CTRL))
        |=> (sfr_rdata[7:6] == 2'b00))
        else $error("reserved control bits read nonzero");
    a_ctrl_reset: assert property (
        $past(srst) |-> (st_ff.ctrl == `TIC_CTRL_RESET))
        else $error("control not zero after reset");

    // Time chain
    a_time_cleared: assert property (
        tc_stop |=> (tick_if.count == 8'h00) && (sec_if.count == 8'h00)
        && (min_if.count == 8'h00) && (hour_if.count == 8'h00))
        else $error("time registers not cleared");
    a_presc_idle: assert property (
        !st_ff.ctrl.timeclock_enable |=> (st_ff.presc == 8'h00))
        else $error("prescaler ran with time clock off");
    a_time_frozen: assert property (
        (!st_ff.ctrl.timeclock_enable && !sfr_wr)
        |=> $stable(tick_if.count) && $stable(hour_if.count))
        else $error("time registers moved with time clock off");
    a_time_preset: assert property (
        (time_wr_ok && (sfr_addr == `TIC_ADDR_SEC))
        |=> (sec_if.count == $past(sfr_wdata)))
        else $error("preset of seconds lost");
    a_time_refused: assert property (
        (st_ff.ctrl.timeclock_enable && sfr_wr
        && (sfr_addr == `TIC_ADDR_TICK) && !tick_if.inc)
        |=> $stable(tick_if.count))
        else $error("tick written while time clock on");
    a_presc_step: assert property (
        (xedge && st_ff.ctrl.timeclock_enable)
        |=> (st_ff.presc == $past(st_ff.presc) + 8'h01))
        else $error("prescaler missed a crystal edge");
    a_tick_div: assert property (
        tick_if.inc |-> (st_ff.presc == `TIC_PRESC_MAX) && xedge)
        else $error("tick not from divide by 256");
    a_tick_step: assert property (
        (tick_if.inc && !tc_stop && (tick_if.count < `TIC_TICK_MAX))
        |=> (tick_if.count == $past(tick_if.count) + 8'h01))
        else $error("tick register did not step");
    a_tick_carry: assert property (
        (tick_if.inc && (tick_if.count == `TIC_TICK_MAX)) |-> sec_if.inc)
        else $error("tick wrap lost");
    a_sec_carry: assert property (
        (sec_if.inc && (sec_if.count == `TIC_SEC_MAX)) |-> min_if.inc)
        else $error("second wrap lost");
    a_min_carry: assert property (
        (min_if.inc && (min_if.count == `TIC_MIN_MAX)) |-> hour_if.inc)
        else $error("minute wrap lost");
    a_hour_wrap: assert property (
        (hour_if.inc && (hour_if.count == `TIC_HOUR_MAX) && !hour_if.load)
        |=> (hour_if.count == 8'h00))
        else $error("hour wrap wrong");

    c_timeout: cover property (timeout);
    c_single_shot: cover property (timeout && st_ff.ctrl.single_shot);
    c_periodic: cover property (timeout && !st_ff.ctrl.single_shot);
    c_wake: cover property (wake_req);
    c_min_wrap: cover property (min_if.wrap);

endmodule

// ===== bench/tic_timer_tb_top.sv
/*
 * Self-checking bench of the time interval counter: register access,
 * time chain wraps, timebase choice and interval timeouts.
 * Assumes the crystal is a slow level driven here, one edge per 4 cycles.
 */
`timescale 1ns/10ps
`include "tic_consts.svh"
module tic_timer_tb_top;
    logic        ref_clk;
    logic        srst;
    logic        xtal_clk;
    logic [7:0]  sfr_addr;
    logic        sfr_wr;
    logic [7:0]  sfr_wdata;
    logic        sfr_rd;
    logic [7:0]  sfr_rdata;
    logic        irq_enable;
    logic        power_down;
    logic        irq_req;
    logic        wake_req;
    logic [15:0] wake_vector;
    logic [7:0]  rv;
    logic [7:0]  pre [4] = '{8'h7f, 8'h3b, 8'h3b, 8'h17};
    int          n_errors;
    int          checked;
    int          cycles;

    tic_timer DUT (.ref_clk(ref_clk), .srst(srst), .xtal_clk(xtal_clk),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .irq_enable(irq_enable),
        .power_down(power_down), .irq_req(irq_req), .wake_req(wake_req),
        .wake_vector(wake_vector));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] ctl(input logic [1:0] tb,
        input logic ss, input logic fl, input logic ie, input logic tc);
        // Bit 6 kept high for later parts
        return {2'b01, tb, ss, fl, ie, tc};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge ref_clk);
        sfr_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge ref_clk);
        sfr_rd   <= 1'b0;
        @(posedge ref_clk);
        d = sfr_rdata;
    endtask

    task automatic xedges(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            xtal_clk <= 1'b1;
            repeat (2) @(posedge ref_clk);
            xtal_clk <= 1'b0;
            @(posedge ref_clk);
        end
        repeat (3) @(posedge ref_clk);
    endtask
    // Whole run needs about 12k cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            final_report();
        end
    end

    initial
    begin
        srst = 1'b1;
        xtal_clk = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        sfr_rd = 1'b0;
        irq_enable = 1'b1;
        power_down = 1'b0;
        n_errors = 0;
        checked = 0;
        cycles = 0;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        // A7 is unmapped and must read zero
        for (int a = 8'ha1; a <= 8'ha7; a++)
        begin
            rd(a[7:0], rv);
            chk(rv, 8'h00);
        end
        chk(wake_vector, `TIC_ISR_VECTOR);
        wr(`TIC_ADDR_CTRL, ctl(2'h3, 1'b1, 1'b0, 1'b0, 1'b0));
        rd(`TIC_ADDR_CTRL, rv);
        chk(rv, 8'h38);
        $display("Test reset and control done");

        wr(`TIC_ADDR_CTRL, 8'h40);
        for (int i = 0; i < 4; i++)
        begin
            wr(`TIC_ADDR_TICK + i[7:0], pre[i]);
            rd(`TIC_ADDR_TICK + i[7:0], rv);
            chk(rv, pre[i]);
        end
        wr(`TIC_ADDR_CTRL, 8'h41);
        // Refused while running, else tick would not wrap to zero
        wr(`TIC_ADDR_TICK, 8'h05);
        xedges(256);
        for (int i = 0; i < 4; i++)
        begin
            rd(`TIC_ADDR_TICK + i[7:0], rv);
            chk(rv, 8'h00);
        end
        xedges(256);
        rd(`TIC_ADDR_TICK, rv);
        chk(rv, 8'h01);
        wr(`TIC_ADDR_CTRL, 8'h40);
        rd(`TIC_ADDR_TICK, rv);
        chk(rv, 8'h00);
        $display("Test time chain done");

        for (int tb = 0; tb < 4; tb++)
        begin
            wr(`TIC_ADDR_CTRL, 8'h40);
            wr(`TIC_ADDR_TICK, 8'h7f);
            wr(`TIC_ADDR_SEC, (tb >= 2) ? 8'h3b : 8'h00);
            wr(`TIC_ADDR_MIN, (tb == 3) ? 8'h3b : 8'h00);
            wr(`TIC_ADDR_CMP, 8'h01);
            wr(`TIC_ADDR_CTRL, ctl(tb[1:0], 1'b1, 1'b0, 1'b1, 1'b1));
            xedges(255);
            chk(irq_req, 1'b0);
            power_down <= (tb == 3);
            xedges(1);
            chk(irq_req, 1'b1);
            chk(wake_req, tb == 3);
            rd(`TIC_ADDR_CTRL, rv);
            chk(rv, ctl(tb[1:0], 1'b1, 1'b1, 1'b0, 1'b1) & 8'h3f);
        end
        repeat (2) @(posedge ref_clk);
        chk(wake_req, 1'b1);
        irq_enable <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({irq_req, wake_req}, 2'b00);
        irq_enable <= 1'b1;
        power_down <= 1'b0;
        wr(`TIC_ADDR_CTRL, ctl(2'h3, 1'b1, 1'b0, 1'b0, 1'b1));
        repeat (2) @(posedge ref_clk);
        chk(irq_req, 1'b0);
        $display("Test timebase and single shot done");

        wr(`TIC_ADDR_CTRL, 8'h40);
        wr(`TIC_ADDR_CMP, 8'h02);
        wr(`TIC_ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, 1'b1, 1'b1));
        xedges(256);
        // Disable mid-count must zero the count
        wr(`TIC_ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, 1'b0, 1'b1));
        wr(`TIC_ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, 1'b1, 1'b1));
        xedges(256);
        chk(irq_req, 1'b0);
        xedges(256);
        chk(irq_req, 1'b1);
        wr(`TIC_ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, 1'b1, 1'b1));
        repeat (2) @(posedge ref_clk);
        chk(irq_req, 1'b0);
        xedges(512);
        rd(`TIC_ADDR_CTRL, rv);
        chk(rv, 8'h07);
        $display("Test periodic interval done");
        final_report();
    end
endmodule
